// ---- design/tlic_top.v ----
/*
 Two-level interrupt controller for an 8-bit core.
 Assumes: core accepts a request by pulsing ack, signals return by reti.
 Primary enables and priorities for the other sources arrive as ports.
*/
// Overview of operation
// - Secondary bits 2,1,0 enable interval, supply monitor, serial periph.
// - Secondary bits 6,5,4 pick high level for the same sources.
// - Secondary register at A9H, resets to A0H, whole-byte access only.
// - Each source has its own enable; masked requests never reach the core.
// - Each source is placed at high or low level by software.
// - An enabled high request preempts a running low routine at once.
// - Simultaneous requests of both levels: the high one is vectored first.
// - No preemption by a request of the level already in service.
// - Same-level ties go by a fixed polling order, supply monitor first.
// - On acceptance the core pushes the PC and loads the vector.
// - Each source has its own fixed vector address.
// - Interval request is raised when the count matches the loaded value.
`timescale 1ns/1ns
`default_nettype none
`include "tlic_map.vh"

module tlic_top #(
  parameter NSRC = `TLIC_NSRC
) (
  input wire clk_i,
  input wire rstn_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire global_irq_enable_i,
  input wire [7:0] primary_enable_i,
  input wire [7:0] primary_priority_i,
  input wire supply_monitor_request_i,
  input wire watchdog_request_i,
  input wire external0_request_i,
  input wire converter_request_i,
  input wire timer0_overflow_request_i,
  input wire external1_request_i,
  input wire timer1_overflow_request_i,
  input wire serial_periph_request_i,
  input wire serial_port_request_i,
  input wire timer2_request_i,
  input wire interval_tick_i,
  input wire [7:0] interval_value_i,
  input wire interval_flag_clear_i,
  input wire irq_ack_i,
  input wire reti_i,
  output reg [7:0] sfr_rdata_o,
  output reg [7:0] sec_reg_o,
  output reg irq_req_o,
  output reg [15:0] irq_vector_o,
  output reg [3:0] irq_source_o,
  output reg irq_level_o,
  output reg push_pc_o,
  output reg load_pc_o,
  output reg interval_flag_o,
  output reg [1:0] in_service_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_sync1;
  reg rst_n;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // ----------------------------------------
  // Secondary register
  // ----------------------------------------
  wire [7:0] sec_value;
  tlic_sec_reg u_sec (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .sfr_wr_i(sfr_wr_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .value_o(sec_value)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function sec_hit;
    input [7:0] addr;
    begin
      sec_hit = (addr == `TLIC_SEC_ADDR);
    end
  endfunction

  // ----------------------------------------
  // Register mirror
  // ----------------------------------------
  // Lags the register by a cycle so the port stays a plain flip-flop
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sec_reg_o <= `TLIC_SEC_RESET;
    end else begin
      sec_reg_o <= sec_value;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped reads return zero rather than holding stale data
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i && sec_hit(sfr_addr_i)) begin
      sfr_rdata_o <= sec_value;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Interval counter match
  // ----------------------------------------
  reg [7:0] interval_count;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      interval_count <= 8'h00;
      interval_flag_o <= 1'b0;
    end else begin
      if (interval_tick_i) begin
        if (interval_count == interval_value_i) begin
          interval_count <= 8'h00;
        end else begin
          interval_count <= interval_count + 8'h01;
        end
      end
      // Set wins over a clear in the same cycle
      if (interval_tick_i && interval_count == interval_value_i) begin
        interval_flag_o <= 1'b1;
      end else if (interval_flag_clear_i) begin
        interval_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Request gating
  // ----------------------------------------
  // Primary port bit order follows source indices 1..6 and 8..9 (watchdog..timer 2)
  wire [NSRC-1:0] raw;
  wire [NSRC-1:0] en;
  wire [NSRC-1:0] hi;
  assign raw = {interval_flag_o, timer2_request_i, serial_port_request_i,
                serial_periph_request_i, timer1_overflow_request_i,
                external1_request_i, timer0_overflow_request_i,
                converter_request_i, external0_request_i,
                watchdog_request_i, supply_monitor_request_i};
  assign en = {sec_value[`TLIC_SEC_ETI], primary_enable_i[7],
               primary_enable_i[6], sec_value[`TLIC_SEC_ESI],
               primary_enable_i[5:0], sec_value[`TLIC_SEC_EPSM]};
  assign hi = {sec_value[`TLIC_SEC_PTI], primary_priority_i[7],
               primary_priority_i[6], sec_value[`TLIC_SEC_PSI],
               primary_priority_i[5:0], sec_value[`TLIC_SEC_SUPPLY_MONITOR_IRQ_PRIORITY]};

  // ----------------------------------------
  // Per-source gating
  // ----------------------------------------
  // Level stack: bit 1 high in service, bit 0 low in service
  // A low routine blocks only low requests, so high ones still get through
  wire [NSRC-1:0] live;
  wire [NSRC-1:0] hi_req;
  wire [NSRC-1:0] lo_req;
  wire hi_block;
  wire lo_block;
  assign hi_block = in_service_o[1];
  assign lo_block = in_service_o[1] | in_service_o[0];

  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      assign live[g] = global_irq_enable_i & raw[g] & en[g];
      assign hi_req[g] = live[g] & hi[g] & ~hi_block;
      assign lo_req[g] = live[g] & ~hi[g] & ~lo_block;
    end
  endgenerate

  wire hi_any;
  wire lo_any;
  wire [3:0] hi_idx;
  wire [3:0] lo_idx;
  tlic_arbiter #(.N(NSRC), .W(4)) u_arb_hi (
    .req_i(hi_req),
    .any_o(hi_any),
    .idx_o(hi_idx)
  );
  tlic_arbiter #(.N(NSRC), .W(4)) u_arb_lo (
    .req_i(lo_req),
    .any_o(lo_any),
    .idx_o(lo_idx)
  );

  // ----------------------------------------
  // Vector table
  // ----------------------------------------
  function [15:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        `TLIC_SRC_PSM: vec_of = `TLIC_VEC_PSM;
        `TLIC_SRC_WDG: vec_of = `TLIC_VEC_WDG;
        `TLIC_SRC_EX0: vec_of = `TLIC_VEC_EX0;
        `TLIC_SRC_ADC: vec_of = `TLIC_VEC_ADC;
        `TLIC_SRC_TM0: vec_of = `TLIC_VEC_TM0;
        `TLIC_SRC_EX1: vec_of = `TLIC_VEC_EX1;
        `TLIC_SRC_TM1: vec_of = `TLIC_VEC_TM1;
        `TLIC_SRC_SPI: vec_of = `TLIC_VEC_SPI;
        `TLIC_SRC_SER: vec_of = `TLIC_VEC_SER;
        `TLIC_SRC_TM2: vec_of = `TLIC_VEC_TM2;
        default: vec_of = `TLIC_VEC_TIC;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Next presentation
  // ----------------------------------------
  // Any high winner beats every low one, whatever their polling ranks
  wire [3:0] next_source;
  wire next_level;
  wire next_req;
  assign next_req = hi_any | lo_any;
  assign next_level = hi_any;
  assign next_source = hi_any ? hi_idx : lo_idx;

  // ----------------------------------------
  // Acceptance sequencer
  // ----------------------------------------
  // Request is re-evaluated every idle cycle; ack takes the presented source
  localparam ST_IDLE = 2'd0;
  localparam ST_PUSH = 2'd1;
  localparam ST_LOAD = 2'd2;
  reg [1:0] state;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      irq_req_o <= 1'b0;
      irq_vector_o <= 16'h0000;
      irq_source_o <= 4'h0;
      irq_level_o <= 1'b0;
      push_pc_o <= 1'b0;
      load_pc_o <= 1'b0;
      in_service_o <= 2'b00;
    end else begin
      push_pc_o <= 1'b0;
      load_pc_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          irq_req_o <= next_req;
          irq_source_o <= next_source;
          irq_level_o <= next_level;
          irq_vector_o <= vec_of(next_source);
          if (irq_ack_i && irq_req_o) begin
            irq_req_o <= 1'b0;
            push_pc_o <= 1'b1;
            state <= ST_PUSH;
            if (irq_level_o) begin
              in_service_o[1] <= 1'b1;
            end else begin
              in_service_o[0] <= 1'b1;
            end
          end else if (reti_i) begin
            if (in_service_o[1]) begin
              in_service_o[1] <= 1'b0;
            end else begin
              in_service_o[0] <= 1'b0;
            end
          end
        end
        ST_PUSH: begin
          // Load strictly follows the push so the return address is safe
          load_pc_o <= 1'b1;
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          // A reti here is lost; the core cannot return mid-entry
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // tlic_top
`default_nettype wire

// ---- design/tlic_map.vh ----
/*
 Constants for the two-level interrupt controller: register address,
 field positions, reset value, source indices and vector addresses.
 Assumes nothing; definitions only.
*/
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH

// ----------------------------------------
// Secondary enable/priority register
// ----------------------------------------
`define TLIC_SEC_ADDR 8'hA9
`define TLIC_SEC_RESET 8'hA0
`define TLIC_SEC_ESI 0
`define TLIC_SEC_EPSM 1
`define TLIC_SEC_ETI 2
`define TLIC_SEC_ZERO 3
`define TLIC_SEC_PSI 4
`define TLIC_SEC_SUPPLY_MONITOR_IRQ_PRIORITY 5
`define TLIC_SEC_PTI 6
`define TLIC_SEC_RSVD 7
`define TLIC_SEC_WMASK 8'h77

// ----------------------------------------
// Source indices, in polling order, 0 is highest rank
// ----------------------------------------
`define TLIC_NSRC 11
`define TLIC_SRC_PSM 0
`define TLIC_SRC_WDG 1
`define TLIC_SRC_EX0 2
`define TLIC_SRC_ADC 3
`define TLIC_SRC_TM0 4
`define TLIC_SRC_EX1 5
`define TLIC_SRC_TM1 6
`define TLIC_SRC_SPI 7
`define TLIC_SRC_SER 8
`define TLIC_SRC_TM2 9
`define TLIC_SRC_TIC 10

// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define TLIC_VEC_EX0 16'h0003
`define TLIC_VEC_TM0 16'h000B
`define TLIC_VEC_EX1 16'h0013
`define TLIC_VEC_TM1 16'h001B
`define TLIC_VEC_SER 16'h0023
`define TLIC_VEC_TM2 16'h002B
`define TLIC_VEC_ADC 16'h0033
`define TLIC_VEC_SPI 16'h003B
`define TLIC_VEC_PSM 16'h0043
`define TLIC_VEC_TIC 16'h0053
`define TLIC_VEC_WDG 16'h005B

`endif

// ---- design/tlic_sec_reg.v ----
/*
 Secondary enable/priority register, a byte at special-function address
 A9H. Assumes whole-byte writes and reads from the core's SFR port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tlic_map.vh"

module tlic_sec_reg (
  input wire clk_i,
  input wire rst_n_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] value_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Bit 7 and bit 3 hold their reset value; writes cannot set bit 3
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= `TLIC_SEC_RESET;
    end else if (sfr_wr_i && sfr_addr_i == `TLIC_SEC_ADDR) begin
      value_o <= (sfr_wdata_i & `TLIC_SEC_WMASK) |
                 (value_o & ~`TLIC_SEC_WMASK);
    end
  end

endmodule // tlic_sec_reg
`default_nettype wire

// ---- design/tlic_arbiter.v ----
/*
 Fixed-order arbiter: picks the lowest-index requester in a vector.
 Assumes index 0 is the highest polling rank.
*/
`timescale 1ns/1ns
`default_nettype none

module tlic_arbiter #(
  parameter N = 11,
  parameter W = 4
) (
  input wire [N-1:0] req_i,
  output reg any_o,
  output reg [W-1:0] idx_o
);

  integer k;

  // ----------------------------------------
  // Priority pick
  // ----------------------------------------
  // Loop runs downward so the lowest index is the last to win
  always @* begin
    any_o = 1'b0;
    idx_o = {W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        any_o = 1'b1;
        idx_o = k[W-1:0];
      end
    end
  end

endmodule // tlic_arbiter
`default_nettype wire

// ---- tb/tlic_top_sva.sv ----
/*
 Port checker for the two-level interrupt controller.
 Assumes it is bound to tlic_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module tlic_top_sva #(
  parameter NSRC = 11
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic global_irq_enable_i,
  input wire logic irq_ack_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] sec_reg_o,
  input wire logic irq_req_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic [3:0] irq_source_o,
  input wire logic irq_level_o,
  input wire logic push_pc_o,
  input wire logic load_pc_o,
  input wire logic [1:0] in_service_o
);
  logic [15:0] vt [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
    16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ack_push_load: assert property (irq_ack_i && irq_req_o && !push_pc_o
    && !load_pc_o |=> push_pc_o ##1 load_pc_o) else $error("no push/load");
  a_push_then_load: assert property (push_pc_o |=> load_pc_o && !push_pc_o)
    else $error("load not after push");
  a_global_mask: assert property (!global_irq_enable_i ##1
    !global_irq_enable_i |-> !irq_req_o) else $error("request while masked");
  a_sec_fixed_bits: assert property (sec_reg_o[7] && !sec_reg_o[3])
    else $error("fixed bits changed");
  a_read_value: assert property (sfr_rd_i && sfr_addr_i == 8'hA9 &&
    !sfr_wr_i |=> sfr_rdata_o == sec_reg_o) else $error("read data");
  a_read_unmapped: assert property (sfr_rd_i && sfr_addr_i != 8'hA9
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read data");
  a_vector_table: assert property (irq_req_o && irq_source_o < NSRC
    |-> irq_vector_o == vt[irq_source_o]) else $error("vector mismatch");
  a_high_no_preempt: assert property (in_service_o[1] |-> !irq_req_o)
    else $error("high routine preempted");
  a_low_only_high: assert property (in_service_o == 2'b01 && irq_req_o
    |-> irq_level_o) else $error("low request during low routine");
endmodule // tlic_top_sva
`default_nettype wire

// ---- tb/tlic_core_model.sv ----
/*
 Core sequencer model: acknowledges a presented request after a chosen
 delay and latches the vector it saw. Assumes one clock with the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tlic_core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] delay_i,
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  output var logic irq_ack_o,
  output var logic [15:0] vec_o
);
  logic [3:0] wait_cnt;
  // ----------------------------------------
  // Acceptance, slow or prompt
  // ----------------------------------------
  always @(posedge clk_i) begin
    irq_ack_o <= 1'b0;
    if (!rstn_i || !irq_req_i || irq_ack_o) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= delay_i) begin
      irq_ack_o <= 1'b1;
      vec_o <= irq_vector_i;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // tlic_core_model
`default_nettype wire

// ---- tb/tlic_top_bench.sv ----
/*
 Self-checking bench for tlic_top with a core model and a queue-free
 reference of pending sources. Assumes the 10 MHz core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tlic_top_bench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wr = 1'b0, rd = 1'b0, glb = 1'b1, tick = 1'b0, fclr = 1'b0;
  logic reti = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, pen = 8'h00, ppr = 8'h00, s;
  logic [7:0] ival = 8'h03;
  logic [9:0] req = 10'h000;
  logic [3:0] dly = 4'h0;
  logic [10:0] pend, en, lv;
  logic [31:0] seed = 32'd25695;
  wire [7:0] rdat, sec;
  wire [15:0] vec, mvec;
  wire [3:0] src;
  wire [1:0] isv;
  wire irq, lvl, push, load, flag, ack;
  int failures = 0, checks_done = 0;
  logic [15:0] vt [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
    16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  always #50 clk_i = ~clk_i;
  tlic_top tlic_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_addr_i(addr), .sfr_wdata_i(wdat),
    .global_irq_enable_i(glb), .primary_enable_i(pen),
    .primary_priority_i(ppr), .supply_monitor_request_i(req[0]),
    .watchdog_request_i(req[1]), .external0_request_i(req[2]),
    .converter_request_i(req[3]), .timer0_overflow_request_i(req[4]),
    .external1_request_i(req[5]), .timer1_overflow_request_i(req[6]),
    .serial_periph_request_i(req[7]), .serial_port_request_i(req[8]),
    .timer2_request_i(req[9]), .interval_tick_i(tick),
    .interval_value_i(ival), .interval_flag_clear_i(fclr),
    .irq_ack_i(ack), .reti_i(reti), .sfr_rdata_o(rdat), .sec_reg_o(sec),
    .irq_req_o(irq), .irq_vector_o(vec), .irq_source_o(src),
    .irq_level_o(lvl), .push_pc_o(push), .load_pc_o(load),
    .interval_flag_o(flag), .in_service_o(isv));
  tlic_core_model tlic_core_model_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .delay_i(dly), .irq_req_i(irq), .irq_vector_i(vec), .irq_ack_o(ack),
    .vec_o(mvec));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] v);
    checks_done++;
    if (v !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic sfr(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    sfr(1'b0, a, 8'h00);
    @(negedge clk_i);
    chk("read data", e, rdat);
  endtask
  // Highest level first, then lowest polling index
  function automatic int pick();
    logic [10:0] c;
    c = pend & en;
    if ((c & lv) != 0) c = c & lv;
    for (int j = 0; j < 11; j++) if (c[j]) return j;
    return -1;
  endfunction
  task automatic take(int i);
    int k = 0;
    do begin @(posedge clk_i); k++; end while (load !== 1'b1 && k < 60);
    chk("vector", vt[i], mvec);
  endtask
  task automatic done(int i);
    if (i < 10) req[i] <= 1'b0;
    else fclr <= 1'b1;
    reti <= 1'b1;
    @(posedge clk_i);
    reti <= 1'b0;
    fclr <= 1'b0;
    pend[i] = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdchk(8'hA9, 8'hA0);
    rdchk(8'h55, 8'h00);
    sfr(1'b1, 8'hA9, 8'h77);
    rdchk(8'hA9, 8'hF7);
    $display("register test done");
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_i);
      seed = xs(seed);
      s = seed[7:0] & 8'h77;
      pen <= seed[15:8];
      ppr <= seed[23:16];
      dly <= seed[27:24];
      glb <= 1'b0;
      sfr(1'b1, 8'hA9, s);
      en = {s[2], seed[15:14], s[0], seed[13:8], s[1]};
      lv = {s[6], seed[23:22], s[4], seed[21:16], s[5]};
      seed = xs(seed);
      pend = {1'b0, seed[9:0]};
      req <= seed[9:0];
      repeat (4) @(posedge clk_i);
      chk("global mask", 1'b0, irq);
      glb <= 1'b1;
      for (int j = pick(); j >= 0; j = pick()) begin
        take(j);
        done(j);
      end
      repeat (4) @(posedge clk_i);
      chk("masked", 1'b0, irq);
      req <= 10'h000;
    end
    $display("random rounds done");
    pen <= 8'hFF;
    ppr <= 8'h00;
    sfr(1'b1, 8'hA9, 8'h00);
    req[6] <= 1'b1;
    take(6);
    req[2] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("same level waits", 1'b0, irq);
    ppr <= 8'h02;
    take(2);
    done(2);
    @(posedge clk_i);
    done(6);
    $display("preemption test done");
    sfr(1'b1, 8'hA9, 8'h04);
    repeat (4) begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end
    @(negedge clk_i);
    chk("interval flag", 1'b1, flag);
    take(10);
    done(10);
    $display("interval test done");
    summarize();
  end
endmodule // tlic_top_bench
bind tlic_top tlic_top_sva #(.NSRC(NSRC)) tlic_top_sva_i (.clk_i(clk_i),
  .rstn_i(rstn_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_addr_i(sfr_addr_i), .global_irq_enable_i(global_irq_enable_i),
  .irq_ack_i(irq_ack_i), .sfr_rdata_o(sfr_rdata_o), .sec_reg_o(sec_reg_o),
  .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
  .irq_source_o(irq_source_o), .irq_level_o(irq_level_o),
  .push_pc_o(push_pc_o), .load_pc_o(load_pc_o),
  .in_service_o(in_service_o));
`default_nettype wire
